// *** jpo_pkg.sv ***
// jpo_pkg: constants and types for the test-access port and oscillator pin block
// assumes a single 200 MHz system clock samples every input pin of the test port
package jpo_pkg;
    localparam int IR_W = 4;                          // instruction register width
    localparam int BYP_W = 1;                         // bypass register width
    localparam int ID_W = 32;                         // identification register width
    localparam int DR_W = 16;                         // user data register width
    localparam logic [3:0] IR_RST = 4'h1;             // idcode selected after reset
    localparam logic [3:0] IR_CAP = 4'h1;             // fixed pattern captured into ir
    localparam logic [3:0] INS_EXTEST = 4'h0;         // unused here, routes to bypass
    localparam logic [3:0] INS_IDCODE = 4'h1;         // select identification register
    localparam logic [3:0] INS_USER = 4'h2;           // select user data register
    localparam logic [3:0] INS_BYPASS = 4'hF;         // select bypass register
    localparam logic [31:0] ID_VAL = 32'h1234_5671;   // arbitrary identification value
    localparam logic [15:0] DR_RST = 16'h0000;        // user register after reset
    localparam logic [1:0] SYNC_RST = 2'h0;           // synchroniser reset level
    localparam logic OSC_SEL_GPIO_RST = 1'b0;         // pins start in oscillator use
    localparam logic PULLUP_RST = 1'b0;               // pull-ups off after reset
    localparam logic CLK_SEL_PLL_RST = 1'b0;          // core clock direct after reset

    // tap states, one-hot
    typedef enum logic [15:0] {
        ST_RESET = 16'h0001, ST_IDLE = 16'h0002, ST_SEL_DR = 16'h0004,
        ST_CAP_DR = 16'h0008, ST_SH_DR = 16'h0010, ST_EX1_DR = 16'h0020,
        ST_PAU_DR = 16'h0040, ST_EX2_DR = 16'h0080, ST_UPD_DR = 16'h0100,
        ST_SEL_IR = 16'h0200, ST_CAP_IR = 16'h0400, ST_SH_IR = 16'h0800,
        ST_EX1_IR = 16'h1000, ST_PAU_IR = 16'h2000, ST_EX2_IR = 16'h4000,
        ST_UPD_IR = 16'h8000
    } jpo_state_t;

    // port c pin controls from the system side
    typedef struct packed {
        logic [1:0] gpio_sel;    // per pin: 1 selects port c use
        logic [1:0] dir_out;     // per pin: 1 drives the pin when gpio_sel is also 1
        logic [1:0] dout;        // per pin output value
    } jpo_portc_t;
endpackage : jpo_pkg

// *** jpo_probe.sv ***
// jpo_probe: behavioural test-port probe that steps the tap through whole scans
// assumes the bench pulls the released data-out line high and calls these tasks
`timescale 1ns/100ps
module jpo_probe (
    input  wire logic clk_sys,    // only used to start each test clock cycle
    input  wire logic tdo_pin,    // data-out line level as seen on the board
    output logic      tck,        // test clock, stands low outside scans
    output logic      tms,        // mode select
    output logic      tdi         // serial data to the device
);
    // idle levels match the internal pulls: tms and tdi high, tck low
    initial
    begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
    end

    // one 64 ns test clock cycle; inputs change while tck is low
    task automatic bit_cyc(input logic m, input logic d, output logic q);
        @(negedge clk_sys);
        tms = m;
        tdi = d;
        #32 tck = 1'b1;
        q = tdo_pin;
        #32 tck = 1'b0;
    endtask : bit_cyc

    // mode-select walk, first bit first, data line left at its pulled level
    task automatic walk(input logic [7:0] seq, input int n);
        logic q;
        for (int i = 0; i < n; i++)
            bit_cyc(seq[i], 1'b1, q);
    endtask : walk

    // full scan from idle back to idle; gap stalls the clock after each bit
    task automatic scan(input logic ir, input logic [31:0] din, input int n,
                        input int gap, output logic [31:0] dout);
        logic q;
        dout = '0;
        if (ir)
            walk(8'h03, 4);
        else
            walk(8'h01, 3);
        for (int i = 0; i < n; i++)
        begin
            bit_cyc(i == n - 1, din[i], q);
            dout[i] = q;
            #(gap);
        end
        walk(8'h01, 2);
    endtask : scan
endmodule : jpo_probe

// *** jpo_top.sv ***
// jpo_top: test-access port controller and oscillator pin muxing
// assumes tck, tms, tdi and oscillator pins are asynchronous to clk_sys
`timescale 1ns/100ps
module jpo_top (
    input  wire logic              clk_sys,
    input  wire logic              rst,
    input  wire logic              tck,            // test clock pin, may stop
    input  wire logic              tms,            // mode select pin
    input  wire logic              tdi,            // serial data in pin
    output logic                   tdo_o,          // serial data out value
    output logic                   tdo_oe,         // high while tdo is driven
    input  wire logic              osc_clk,        // oscillator clock from the pins
    input  wire logic              clk_sel_pll,    // 1: oscillator feeds pll
    input  wire jpo_pkg::jpo_portc_t portc_cfg,    // port c controls
    input  wire logic              osc_in_pin,     // pin level, bit 0
    input  wire logic              osc_out_pin,    // pin level, bit 1
    output logic [1:0]             portc_o,        // port c output values
    output logic [1:0]             portc_oe,       // port c output enables
    output logic [1:0]             portc_i,        // port c synchronised inputs
    output logic [1:0]             pullup_en,      // pull-up enables of both pins
    output logic                   core_clk_en,    // oscillator routed to core
    output logic                   pll_ref_en,     // oscillator routed to pll
    output logic [3:0]             ir_out          // active instruction
);
    // three-stage synchronisers for the three test pins
    logic [2:0] tck_s, tms_s, tdi_s;
    logic       tck_q;             // last agreed tck level
    logic       rise, fall;        // one-cycle tck edge enables
    jpo_pkg::jpo_state_t st_reg, st_next;
    logic [3:0]  ir_sh_reg, ir_reg;
    logic [31:0] id_sh_reg;
    logic [15:0] dr_sh_reg, dr_reg;
    logic        byp_reg;
    logic        tdo_next;

    // sync: only stage 2 and 3 are looked at together
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            tck_s <= 3'h0;
            tms_s <= 3'h0;
            tdi_s <= 3'h0;
        end
        else
        begin
            tck_s <= {tck_s[1:0], tck};
            tms_s <= {tms_s[1:0], tms};
            tdi_s <= {tdi_s[1:0], tdi};
        end
    end

    // agreed tck level; a stopped tck just yields no edges
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            tck_q <= 1'b0;
        else if (tck_s[1] == tck_s[2])
            tck_q <= tck_s[2];
    end
    assign rise = (tck_s[1] == tck_s[2]) && tck_s[2] && !tck_q;
    assign fall = (tck_s[1] == tck_s[2]) && !tck_s[2] && tck_q;

    // next tap state from tms
    always_comb
    begin
        unique case (st_reg)
            jpo_pkg::ST_RESET:  st_next = tms_s[2] ? jpo_pkg::ST_RESET : jpo_pkg::ST_IDLE;
            jpo_pkg::ST_IDLE:   st_next = tms_s[2] ? jpo_pkg::ST_SEL_DR : jpo_pkg::ST_IDLE;
            jpo_pkg::ST_SEL_DR: st_next = tms_s[2] ? jpo_pkg::ST_SEL_IR : jpo_pkg::ST_CAP_DR;
            jpo_pkg::ST_CAP_DR: st_next = tms_s[2] ? jpo_pkg::ST_EX1_DR : jpo_pkg::ST_SH_DR;
            jpo_pkg::ST_SH_DR:  st_next = tms_s[2] ? jpo_pkg::ST_EX1_DR : jpo_pkg::ST_SH_DR;
            jpo_pkg::ST_EX1_DR: st_next = tms_s[2] ? jpo_pkg::ST_UPD_DR : jpo_pkg::ST_PAU_DR;
            jpo_pkg::ST_PAU_DR: st_next = tms_s[2] ? jpo_pkg::ST_EX2_DR : jpo_pkg::ST_PAU_DR;
            jpo_pkg::ST_EX2_DR: st_next = tms_s[2] ? jpo_pkg::ST_UPD_DR : jpo_pkg::ST_SH_DR;
            jpo_pkg::ST_UPD_DR: st_next = tms_s[2] ? jpo_pkg::ST_SEL_DR : jpo_pkg::ST_IDLE;
            jpo_pkg::ST_SEL_IR: st_next = tms_s[2] ? jpo_pkg::ST_RESET : jpo_pkg::ST_CAP_IR;
            jpo_pkg::ST_CAP_IR: st_next = tms_s[2] ? jpo_pkg::ST_EX1_IR : jpo_pkg::ST_SH_IR;
            jpo_pkg::ST_SH_IR:  st_next = tms_s[2] ? jpo_pkg::ST_EX1_IR : jpo_pkg::ST_SH_IR;
            jpo_pkg::ST_EX1_IR: st_next = tms_s[2] ? jpo_pkg::ST_UPD_IR : jpo_pkg::ST_PAU_IR;
            jpo_pkg::ST_PAU_IR: st_next = tms_s[2] ? jpo_pkg::ST_EX2_IR : jpo_pkg::ST_PAU_IR;
            jpo_pkg::ST_EX2_IR: st_next = tms_s[2] ? jpo_pkg::ST_UPD_IR : jpo_pkg::ST_SH_IR;
            jpo_pkg::ST_UPD_IR: st_next = tms_s[2] ? jpo_pkg::ST_SEL_DR : jpo_pkg::ST_IDLE;
            default:            st_next = jpo_pkg::ST_RESET;  // illegal code recovers
        endcase
    end

    // tap state steps only on tck rising edges
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            st_reg <= jpo_pkg::ST_RESET;
        else if (rise)
            st_reg <= st_next;
    end

    // instruction shift and update; in reset the instruction falls back to
    // identification on the falling tck, so five high tms bits always recover
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            ir_sh_reg <= jpo_pkg::IR_RST;
            ir_reg    <= jpo_pkg::IR_RST;
        end
        else if (fall && st_reg == jpo_pkg::ST_RESET)
            ir_reg <= jpo_pkg::IR_RST;
        else if (rise)
        begin
            if (st_reg == jpo_pkg::ST_CAP_IR)
                ir_sh_reg <= jpo_pkg::IR_CAP;
            else if (st_reg == jpo_pkg::ST_SH_IR)
                ir_sh_reg <= {tdi_s[2], ir_sh_reg[3:1]};
            else if (st_reg == jpo_pkg::ST_UPD_IR)
                ir_reg <= ir_sh_reg;
        end
    end

    // data registers: bypass, identification, user
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            byp_reg   <= 1'b0;
            id_sh_reg <= jpo_pkg::ID_VAL;
            dr_sh_reg <= jpo_pkg::DR_RST;
            dr_reg    <= jpo_pkg::DR_RST;
        end
        else if (rise)
        begin
            if (st_reg == jpo_pkg::ST_CAP_DR)
            begin
                byp_reg   <= 1'b0;
                id_sh_reg <= jpo_pkg::ID_VAL;
                dr_sh_reg <= dr_reg;
            end
            else if (st_reg == jpo_pkg::ST_SH_DR)
            begin
                // only the selected register moves
                if (ir_reg == jpo_pkg::INS_IDCODE)
                    id_sh_reg <= {tdi_s[2], id_sh_reg[31:1]};
                else if (ir_reg == jpo_pkg::INS_USER)
                    dr_sh_reg <= {tdi_s[2], dr_sh_reg[15:1]};
                else
                    byp_reg <= tdi_s[2];
            end
            else if (st_reg == jpo_pkg::ST_UPD_DR && ir_reg == jpo_pkg::INS_USER)
                dr_reg <= dr_sh_reg;
        end
    end

    // serial output source for the current state
    always_comb
    begin
        if (st_reg == jpo_pkg::ST_SH_IR)
            tdo_next = ir_sh_reg[0];
        else if (ir_reg == jpo_pkg::INS_IDCODE)
            tdo_next = id_sh_reg[0];
        else if (ir_reg == jpo_pkg::INS_USER)
            tdo_next = dr_sh_reg[0];
        else
            tdo_next = byp_reg;
    end

    // output moves only on falling tck, so the tester samples on the next rise
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            tdo_o  <= 1'b0;
            tdo_oe <= 1'b0;
        end
        else if (fall)
        begin
            tdo_o  <= tdo_next;
            tdo_oe <= (st_reg == jpo_pkg::ST_SH_IR) ||
                      (st_reg == jpo_pkg::ST_SH_DR);
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            ir_out <= jpo_pkg::IR_RST;
        else
            ir_out <= ir_reg;
    end

    // oscillator clock routing; a glitch-free switch sits in the clock tree
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            core_clk_en <= ~jpo_pkg::CLK_SEL_PLL_RST;
            pll_ref_en  <= jpo_pkg::CLK_SEL_PLL_RST;
        end
        else
        begin
            core_clk_en <= ~clk_sel_pll;
            pll_ref_en  <= clk_sel_pll;
        end
    end

    // per-pin port c function; oscillator use and pull-ups off after reset
    logic [1:0] pin_lvl;
    assign pin_lvl = {osc_out_pin, osc_in_pin};
    for (genvar g = 0; g < 2; g++)
    begin : g_pin
        logic [2:0] s;
        always_ff @(posedge clk_sys or posedge rst)
        begin
            if (rst)
            begin
                s           <= 3'h0;
                portc_i[g]  <= 1'b0;
                portc_o[g]  <= 1'b0;
                portc_oe[g] <= jpo_pkg::OSC_SEL_GPIO_RST;
                pullup_en[g] <= jpo_pkg::PULLUP_RST;
            end
            else
            begin
                s <= {s[1:0], pin_lvl[g]};
                if (s[1] == s[2])
                    portc_i[g] <= s[2];
                portc_o[g]  <= portc_cfg.dout[g];
                portc_oe[g] <= portc_cfg.gpio_sel[g] & portc_cfg.dir_out[g];
                pullup_en[g] <= jpo_pkg::PULLUP_RST;
            end
        end
    end

    // checks
    // st_reg cannot move in the cycle after a fall, so its sampled value is the one used
    property p_tdo_shift;
        @(posedge clk_sys) disable iff (rst)
        $rose(tdo_oe) |-> $past(fall) &&
            (st_reg == jpo_pkg::ST_SH_IR || st_reg == jpo_pkg::ST_SH_DR);
    endproperty
    a_tdo_shift: assert property (p_tdo_shift) else $error("tdo enabled outside shift");
    property p_tdo_off;
        @(posedge clk_sys) disable iff (rst)
        fall && st_reg != jpo_pkg::ST_SH_IR && st_reg != jpo_pkg::ST_SH_DR |=> !tdo_oe;
    endproperty
    a_tdo_off: assert property (p_tdo_off) else $error("tdo left driven");
    property p_ir_reset;
        @(posedge clk_sys) disable iff (rst)
        fall && st_reg == jpo_pkg::ST_RESET |=> ir_reg == jpo_pkg::IR_RST;
    endproperty
    a_ir_reset: assert property (p_ir_reset) else $error("ir kept in reset");
    property p_tdo_fall;
        @(posedge clk_sys) disable iff (rst) $changed(tdo_o) |-> $past(fall);
    endproperty
    a_tdo_fall: assert property (p_tdo_fall) else $error("tdo changed off falling tck");
    property p_state_rise;
        @(posedge clk_sys) disable iff (rst) $changed(st_reg) |-> $past(rise);
    endproperty
    a_state_rise: assert property (p_state_rise) else $error("tap moved without rise");
    property p_reset_tms;
        @(posedge clk_sys) disable iff (rst)
        rise && tms_s[2] && st_reg == jpo_pkg::ST_SEL_IR |=> st_reg == jpo_pkg::ST_RESET;
    endproperty
    a_reset_tms: assert property (p_reset_tms) else $error("tap missed reset");
    property p_byp;
        @(posedge clk_sys) disable iff (rst)
        rise && st_reg == jpo_pkg::ST_SH_DR && ir_reg == jpo_pkg::INS_BYPASS
        |=> byp_reg == $past(tdi_s[2]);
    endproperty
    a_byp: assert property (p_byp) else $error("bypass lost tdi");
    property p_stop;
        @(posedge clk_sys) disable iff (rst) !rise |=> $stable(st_reg);
    endproperty
    a_stop: assert property (p_stop) else $error("tap moved while tck idle");
    property p_clk_route;
        @(posedge clk_sys) disable iff (rst) core_clk_en != pll_ref_en;
    endproperty
    a_clk_route: assert property (p_clk_route) else $error("clock routes overlap");
    property p_pll;
        @(posedge clk_sys) disable iff (rst) clk_sel_pll |=> pll_ref_en;
    endproperty
    a_pll: assert property (p_pll) else $error("pll reference not selected");
    property p_gpio;
        @(posedge clk_sys) disable iff (rst)
        !portc_cfg.gpio_sel[0] |=> !portc_oe[0];
    endproperty
    a_gpio: assert property (p_gpio) else $error("osc pin driven as gpio");
    property p_pull;
        @(posedge clk_sys) disable iff (rst) pullup_en == 2'h0;
    endproperty
    a_pull: assert property (p_pull) else $error("pull-up enabled");
    c_shdr: cover property (@(posedge clk_sys) disable iff (rst) st_reg == jpo_pkg::ST_SH_DR);
    c_shir: cover property (@(posedge clk_sys) disable iff (rst) st_reg == jpo_pkg::ST_SH_IR);
    c_user: cover property (@(posedge clk_sys) disable iff (rst) ir_reg == jpo_pkg::INS_USER);
endmodule : jpo_top

// *** tb.sv ***
// tb: self-checking bench for the test port and oscillator pin block
// assumes jpo_top with its in-file assertions and the jpo_probe model
`timescale 1ns/100ps
module tb;
    typedef struct packed {
        logic [3:0]  ins;         // instruction to load
        logic [5:0]  n;           // data bits to shift
        logic [31:0] din;         // data shifted in
        logic [31:0] exp;         // data expected out
        logic [15:0] gap;         // clock stall after each bit, ns
    } jpo_row_t;
    localparam jpo_row_t ROWS [6] = '{
        '{jpo_pkg::INS_IDCODE, 6'h20, 32'h0000_0000, jpo_pkg::ID_VAL, 16'h0000},
        '{jpo_pkg::INS_USER, 6'h10, 32'h0000_A5C3, 32'h0000_0000, 16'h0000},
        '{jpo_pkg::INS_USER, 6'h10, 32'h0000_0F0F, 32'h0000_A5C3, 16'h012C},
        '{jpo_pkg::INS_BYPASS, 6'h20, 32'h8765_4321, 32'h0ECA_8642, 16'h0000},
        '{jpo_pkg::INS_EXTEST, 6'h08, 32'h0000_00B5, 32'h0000_006A, 16'h0000},
        '{jpo_pkg::INS_IDCODE, 6'h20, 32'hFFFF_FFFF, jpo_pkg::ID_VAL, 16'h0000}};
    localparam logic [5:0] CFGS [4] = '{6'h3E, 6'h35, 6'h1F, 6'h0F};

    logic               clk_sys, rst, tck, tms, tdi, tdo_o, tdo_oe, osc_clk, clk_sel_pll;
    logic               osc_in_pin, osc_out_pin, tdo_pin, core_clk_en, pll_ref_en;
    jpo_pkg::jpo_portc_t portc_cfg;
    logic [1:0]         portc_o, portc_oe, portc_i, pullup_en, ext;
    logic [3:0]         ir_out;
    logic [31:0]        q;
    int                 mismatches, comparisons;

    // released data-out line floats up through its pull-up
    assign tdo_pin     = tdo_oe ? tdo_o : 1'b1;
    // pins follow the block when it drives them, else the outside level
    assign osc_in_pin  = portc_oe[0] ? portc_o[0] : ext[0];
    assign osc_out_pin = portc_oe[1] ? portc_o[1] : ext[1];

    jpo_top dut (.clk_sys(clk_sys), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi),
        .tdo_o(tdo_o), .tdo_oe(tdo_oe), .osc_clk(osc_clk), .clk_sel_pll(clk_sel_pll),
        .portc_cfg(portc_cfg), .osc_in_pin(osc_in_pin), .osc_out_pin(osc_out_pin),
        .portc_o(portc_o), .portc_oe(portc_oe), .portc_i(portc_i),
        .pullup_en(pullup_en), .core_clk_en(core_clk_en), .pll_ref_en(pll_ref_en),
        .ir_out(ir_out));
    jpo_probe probe (.clk_sys(clk_sys), .tdo_pin(tdo_pin), .tck(tck), .tms(tms),
        .tdi(tdi));

    // 200 MHz system clock and an 8 MHz oscillator
    initial
    begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    initial
    begin
        osc_clk = 1'b0;
        forever #62.5 osc_clk = ~osc_clk;
    end

    // compare one value, count it, report a difference at once
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        comparisons++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    // let synchronisers and registered outputs settle
    task automatic settle();
        repeat (8) @(negedge clk_sys);
    endtask : settle

    task automatic print_verdict();
        $display("compares %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : print_verdict

    // hang guard, about twelve times the expected run
    initial
    begin
        #300000;
        mismatches++;
        $display("BAD %0t watchdog expired", $time);
        print_verdict();
    end

    // reset values, table of scans, then the awkward cases
    initial
    begin
        mismatches = 0;
        comparisons = 0;
        rst = 1'b1;
        clk_sel_pll = 1'b0;
        portc_cfg = '0;
        ext = 2'b01;
        repeat (2) @(negedge clk_sys);
        rst = 1'b0;
        check(tdo_oe, 0, "oe after reset");
        check(core_clk_en, 1, "core clk after reset");
        check(pll_ref_en, 0, "pll ref after reset");
        check({portc_oe, pullup_en}, 0, "pins after reset");
        check(ir_out, jpo_pkg::IR_RST, "ir after reset");
        $display("reset test done");
        probe.walk(8'h1F, 6);
        // table: load instruction, then shift its data register
        foreach (ROWS[r])
        begin
            probe.scan(1'b1, {28'h0, ROWS[r].ins}, 4, 0, q);
            check(q, jpo_pkg::IR_CAP, "ir capture");
            check(ir_out, ROWS[r].ins, "ir update");
            probe.scan(1'b0, ROWS[r].din, ROWS[r].n, ROWS[r].gap, q);
            check(q, ROWS[r].exp, "dr shift");
            settle();
            check(tdo_oe, 0, "oe in idle");
            $display("row %0d done", r);
        end
        // abort a data shift by holding mode select high
        probe.scan(1'b1, 32'h0000_0002, 4, 0, q);
        probe.walk(8'h01, 5);
        settle();
        check(tdo_oe, 1, "oe in shift");
        probe.walk(8'h1F, 5);
        settle();
        check(tdo_oe, 0, "oe after abort");
        check(ir_out, jpo_pkg::IR_RST, "ir after abort");
        probe.walk(8'h00, 1);
        $display("abort test done");
        // core clock source select both ways
        for (int s = 0; s < 2; s++)
        begin
            clk_sel_pll = s[0];
            settle();
            check(core_clk_en, !s[0], "core clk select");
            check(pll_ref_en, s[0], "pll ref select");
        end
        $display("clock select test done");
        // port c: each pin with its own use, direction and value
        foreach (CFGS[k])
        begin
            portc_cfg = CFGS[k];
            ext = ~CFGS[k][1:0];
            settle();
            check(portc_oe, CFGS[k][5:4] & CFGS[k][3:2], "portc oe");
            check(portc_o & CFGS[k][5:4] & CFGS[k][3:2],
                CFGS[k][5:4] & CFGS[k][3:2] & CFGS[k][1:0], "portc out");
            check(portc_i, (CFGS[k][5:4] & CFGS[k][3:2] & CFGS[k][1:0])
                | (~(CFGS[k][5:4] & CFGS[k][3:2]) & ext), "portc in");
            check(pullup_en, 0, "pullups off");
        end
        $display("port c test done");
        // second reset in mid-shift, pins in port c use and the pll selected
        portc_cfg = 6'h3F;
        probe.scan(1'b1, 32'h0000_0002, 4, 0, q);
        probe.walk(8'h01, 3);
        settle();
        check(tdo_oe, 1, "oe before reset");
        check(portc_oe, 2'b11, "portc oe before reset");
        rst = 1'b1;
        repeat (2) @(negedge clk_sys);
        check({portc_oe, pullup_en}, 0, "pins in reset");
        check({core_clk_en, pll_ref_en}, 2'b10, "clock in reset");
        check({tdo_oe, ir_out}, {1'b0, jpo_pkg::IR_RST}, "tap in reset");
        rst = 1'b0;
        // the port must work again from the reset state
        probe.walk(8'h00, 1);
        probe.scan(1'b0, 32'h0000_0000, 32, 0, q);
        check(q, jpo_pkg::ID_VAL, "id after reset");
        $display("second reset test done");
        print_verdict();
    end
endmodule : tb
